// File: pkg/hiresr_pkg.sv
// Constants for the high-resolution inductance result register slice
package hiresr_pkg;
   // ==========================================================
   // Register addresses on the serial register port
   localparam logic [7:0] ADDR_OFFSET_LOW = 8'h32;
   localparam logic [7:0] ADDR_OFFSET_HIGH = 8'h33;
   localparam logic [7:0] ADDR_CONFIG = 8'h34;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'h38;
   localparam logic [7:0] ADDR_RESULT_MID = 8'h39;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h3a;
   localparam logic [7:0] ADDR_ERROR_FLAGS = 8'h3b;

   // ==========================================================
   // Widths and reset values
   localparam int BYTE_W = 8;
   localparam int RESULT_W = 24;
   localparam int OFFSET_W = 16;
   localparam int DIV_W = 2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [23:0] RESET_RESULT = 24'h000000;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ==========================================================
   // Field positions
   localparam int DIV_LSB = 0;
   localparam int FLAG_READY = 0;
   localparam int FLAG_OVERFLOW = 1;
   localparam int FLAG_UNDER = 2;
   localparam int FLAG_OVER = 3;
   localparam int FLAG_ZERO = 4;
   // Offset word lines up with the top 16 bits of the result
   localparam int OFFSET_SHIFT = 8;

   // ==========================================================
   // Sensor divider encodings
   typedef enum logic [1:0]
   {
      HIRESR_DIV1 = 2'b00,
      HIRESR_DIV2 = 2'b01,
      HIRESR_DIV4 = 2'b10,
      HIRESR_DIV8 = 2'b11
   } hiresr_div_t;
endpackage

// File: rtl/hiresr_byte_reg.sv
// One software-writable byte register with synchronous reset
`timescale 1ns/1ps
module hiresr_byte_reg
   import hiresr_pkg::*;
#(
   parameter logic [7:0] RESET_VALUE = RESET_BYTE
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] value_r
);
   always_ff @(posedge clk)
   begin
      if (rst)
         value_r <= RESET_VALUE;
      else if (wr_en)
         value_r <= wr_data;
   end
endmodule

// File: rtl/hiresr_regs.sv
// Register slice of the high-resolution inductance measurement channel
`timescale 1ns/1ps
// Operation
// R1: Offset word is {high byte, low byte at 0x32}, applied to results.
// R2: Config bits 1:0 divide the sensor by 1/2/4/8; host writes 7:2 zero.
// R3: Result bytes 7:0, 15:8, 23:16 read at 0x38, 0x39, 0x3A.
// R4: Host reads 0x38, then 0x39, then 0x3A for a coherent result.
// R5: Sensor freq = reference clock x divider x result / 2^24.
// R6: A 0x38 read freezes the middle and top bytes of the same conversion.
// R7: Error flags refresh only when the host reads the low result byte.
// R8: Under-range is flagged when the offset makes the code negative.
module hiresr_regs
   import hiresr_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] OFFSET_LOW_BYTE,
   input wire logic CONV_DONE,
   input wire logic [23:0] CONV_RAW,
   input wire logic CONV_ZERO_COUNT,
   input wire logic CONV_OVER_RANGE,
   input wire logic CONV_OVERFLOW,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   output logic [1:0] SENSOR_DIV,
   output logic [15:0] OFFSET_WORD
);
   // ==========================================================
   // Software registers
   logic [7:0] offset_high_r;
   logic [7:0] config_r;

   hiresr_byte_reg #(.RESET_VALUE(RESET_BYTE)) u_offset_high
   (
      .clk(CLK_SYS),
      .rst(RST),
      .wr_en(REG_WR && REG_ADDR == ADDR_OFFSET_HIGH),
      .wr_data(REG_WDATA),
      .value_r(offset_high_r)
   );

   // Reserved bits are stored as written; software keeps them zero
   hiresr_byte_reg #(.RESET_VALUE(RESET_BYTE)) u_config
   (
      .clk(CLK_SYS),
      .rst(RST),
      .wr_en(REG_WR && REG_ADDR == ADDR_CONFIG),
      .wr_data(REG_WDATA),
      .value_r(config_r)
   );

   // ==========================================================
   // Settings driven to the sensing core
   logic [15:0] offset_nxt;
   assign offset_nxt = {offset_high_r, OFFSET_LOW_BYTE};

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         OFFSET_WORD <= {BYTE_W'(RESET_BYTE), BYTE_W'(RESET_BYTE)};
         SENSOR_DIV <= HIRESR_DIV1;
      end
      else
      begin
         OFFSET_WORD <= offset_nxt; // R1
         SENSOR_DIV <= config_r[DIV_LSB +: DIV_W]; // R2
      end
   end

   // ==========================================================
   // Offset subtraction of each finished conversion
   logic [23:0] offset_scaled;
   logic [24:0] diff_nxt;
   logic under_nxt;
   assign offset_scaled = {OFFSET_WORD, BYTE_W'(RESET_BYTE)};
   assign diff_nxt = {1'b0, CONV_RAW} - {1'b0, offset_scaled}; // R1
   assign under_nxt = diff_nxt[RESULT_W]; // R8

   logic [23:0] live_result_r;
   logic [4:0] live_flags_r;

   // Raw count already scales to the sensor frequency; only offset applies
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         live_result_r <= RESET_RESULT;
         live_flags_r <= 5'h00;
      end
      else if (CONV_DONE)
      begin
         // A negative code reads as zero rather than wrapping
         live_result_r <= under_nxt ? RESET_RESULT
                                    : diff_nxt[RESULT_W-1:0]; // R5
         live_flags_r[FLAG_ZERO] <= CONV_ZERO_COUNT;
         live_flags_r[FLAG_OVER] <= CONV_OVER_RANGE;
         live_flags_r[FLAG_UNDER] <= under_nxt; // R8
         live_flags_r[FLAG_OVERFLOW] <= CONV_OVERFLOW;
         live_flags_r[FLAG_READY] <= 1'b0;
      end
   end

   // ==========================================================
   // Read snapshot
   logic low_read;
   assign low_read = REG_RD && REG_ADDR == ADDR_RESULT_LOW;

   logic [15:0] snap_upper_r;
   logic [4:0] snap_flags_r;
   logic ready_r;

   // Later conversions cannot tear the word between the three reads
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         snap_upper_r <= {BYTE_W'(RESET_BYTE), BYTE_W'(RESET_BYTE)};
         snap_flags_r <= 5'h00;
      end
      else if (low_read)
      begin
         snap_upper_r <= live_result_r[RESULT_W-1:BYTE_W]; // R6
         snap_flags_r <= live_flags_r; // R7
      end
   end

   // Ready flag: a conversion in the same cycle as the low read wins
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         ready_r <= 1'b0;
      else if (CONV_DONE)
         ready_r <= 1'b1;
      else if (low_read)
         ready_r <= 1'b0;
   end

   // ==========================================================
   // Read data path
   logic [7:0] rdata_nxt;
   always_comb
   begin
      rdata_nxt = READ_ZERO;
      unique case (REG_ADDR)
         ADDR_OFFSET_HIGH: rdata_nxt = offset_high_r;
         ADDR_CONFIG: rdata_nxt = config_r;
         ADDR_RESULT_LOW: rdata_nxt = live_result_r[BYTE_W-1:0]; // R3
         ADDR_RESULT_MID: rdata_nxt = snap_upper_r[BYTE_W-1:0]; // R3
         ADDR_RESULT_HIGH: rdata_nxt = snap_upper_r[OFFSET_W-1:BYTE_W];
         ADDR_ERROR_FLAGS:
         begin
            rdata_nxt = {3'b000, snap_flags_r};
            rdata_nxt[FLAG_READY] = ready_r;
         end
         default: rdata_nxt = READ_ZERO;
      endcase
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         REG_RDATA <= READ_ZERO;
         REG_RVALID <= 1'b0;
      end
      else
      begin
         REG_RVALID <= REG_RD;
         if (REG_RD)
            REG_RDATA <= rdata_nxt;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   a_offset_word_tracks: assert property ( // R1
      REG_WR && REG_ADDR == ADDR_OFFSET_HIGH ##1 $stable(OFFSET_LOW_BYTE)
      |=> OFFSET_WORD == {$past(REG_WDATA, 2), $past(OFFSET_LOW_BYTE)})
      else $error("offset word does not follow high byte write");

   a_div_from_config: assert property ( // R2
      REG_WR && REG_ADDR == ADDR_CONFIG ##1 !REG_WR
      |=> SENSOR_DIV == $past(REG_WDATA[1:0], 2))
      else $error("sensor divider does not follow config write");

   a_low_byte_read: assert property ( // R3
      low_read
      |=> REG_RVALID && REG_RDATA == $past(live_result_r[7:0]))
      else $error("low result byte read wrong");

   a_mid_coherent: assert property ( // R6
      low_read ##1 !low_read && REG_RD && REG_ADDR == ADDR_RESULT_MID
      |=> REG_RDATA == $past(live_result_r[15:8], 2))
      else $error("middle byte not from the same conversion");

   a_high_coherent: assert property ( // R6
      (low_read ##1 !low_read [*2])
      ##0 (REG_RD && REG_ADDR == ADDR_RESULT_HIGH)
      |=> REG_RDATA == $past(live_result_r[23:16], 3))
      else $error("top byte not from the same conversion");

   a_flags_hold: assert property ( // R7
      !low_read |=> $stable(snap_flags_r))
      else $error("error flags changed without a low byte read");

   a_under_range: assert property ( // R8
      CONV_DONE && CONV_RAW < {OFFSET_WORD, 8'h00}
      |=> live_flags_r[FLAG_UNDER] && live_result_r == 24'h000000)
      else $error("under-range not flagged");

   a_result_offset: assert property ( // R5
      CONV_DONE && CONV_RAW >= {OFFSET_WORD, 8'h00}
      |=> live_result_r == $past(CONV_RAW) - {$past(OFFSET_WORD), 8'h00})
      else $error("result not offset-corrected");

   a_ready_set_wins: assert property (
      CONV_DONE && low_read |=> ready_r)
      else $error("ready flag lost on simultaneous clear");

   c_coherent_read: cover property (
      low_read ##1 REG_RD && REG_ADDR == ADDR_RESULT_MID
      ##1 REG_RD && REG_ADDR == ADDR_RESULT_HIGH);
   c_under_range: cover property (CONV_DONE && under_nxt);
   c_conv_mid_read: cover property (low_read ##1 CONV_DONE);
   c_div8: cover property (SENSOR_DIV == HIRESR_DIV8);
endmodule

// File: tb/hires_inductance_result_regs_test.sv
// Self-checking bench for the high-resolution result register slice
`timescale 1ns/1ps
module hires_inductance_result_regs_test import hiresr_pkg::*;;
   logic clk, rst, reg_wr, reg_rd, conv_done, zc, orng, ovf, rvalid;
   logic [7:0] reg_addr, reg_wdata, off_lo, rdata, b;
   logic [23:0] conv_raw, v;
   logic [1:0] div;
   logic [15:0] offw;
   logic [7:0] regs [6] = '{8'h33, 8'h34, 8'h38, 8'h39, 8'h3a, 8'h3b};
   int failures = 0;
   int num_checks = 0;

   hiresr_regs i_dut (.CLK_SYS(clk), .RST(rst), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .OFFSET_LOW_BYTE(off_lo), .CONV_DONE(conv_done), .CONV_RAW(conv_raw),
      .CONV_ZERO_COUNT(zc), .CONV_OVER_RANGE(orng), .CONV_OVERFLOW(ovf),
      .REG_RDATA(rdata), .REG_RVALID(rvalid), .SENSOR_DIV(div),
      .OFFSET_WORD(offw));
   hiresr_host i_host (.clk(clk), .rdata(rdata), .rvalid(rvalid),
      .wr(reg_wr), .rd(reg_rd), .addr(reg_addr), .wdata(reg_wdata));

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
   begin
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask

   task automatic final_report();
   begin
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask

   task automatic conv(input logic [23:0] raw, input logic [2:0] e);
   begin
      @(posedge clk);
      #1;
      conv_done = 1'b1;
      conv_raw = raw;
      {zc, orng, ovf} = e;
      @(posedge clk);
      #1;
      conv_done = 1'b0;
      conv_raw = ~raw;
      {zc, orng, ovf} = ~e;
   end
   endtask

   // ==========================================================
   // Clock, watchdog and tests
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      #100us;
      failures++;
      final_report();
   end

   initial
   begin
      rst = 1'b1;
      off_lo = 8'h00;
      conv_done = 1'b0;
      conv_raw = 24'h000000;
      {zc, orng, ovf} = 3'b000;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      chk(24'(div), 24'h0);
      chk(24'(offw), 24'h0);
      foreach (regs[i])
      begin
         i_host.read(regs[i], b);
         chk(24'(b), 24'h0);
      end
      // Reserved config bits stay zero, as the host must write them
      for (int i = 0; i < 4; i++)
      begin
         i_host.write(ADDR_CONFIG, 8'(i));
         @(posedge clk);
         #1;
         chk(24'(div), 24'(i));
         i_host.read(ADDR_CONFIG, b);
         chk(24'(b), 24'(i));
      end
      off_lo = 8'h34;
      i_host.write(ADDR_OFFSET_HIGH, 8'h12);
      // Result bytes are read-only: this write must be ignored
      i_host.write(ADDR_RESULT_LOW, 8'h55);
      @(posedge clk);
      #1;
      chk(24'(offw), 24'h1234);
      i_host.read(ADDR_OFFSET_HIGH, b);
      chk(24'(b), 24'h12);
      i_host.read(ADDR_RESULT_LOW, b);
      chk(24'(b), 24'h0);
      i_host.read(8'h3c, b);
      chk(24'(b), 24'h0);
      // Second conversion lands between low and upper byte reads
      conv(24'habcdef, 3'b000);
      i_host.read(ADDR_ERROR_FLAGS, b);
      chk(24'(b), 24'h01);
      i_host.read(ADDR_RESULT_LOW, v[7:0]);
      conv(24'hfedcba, 3'b000);
      i_host.read(ADDR_RESULT_MID, v[15:8]);
      i_host.read(ADDR_RESULT_HIGH, v[23:16]);
      chk(v, 24'h9999ef);
      conv(24'h000010, 3'b111);
      i_host.read(ADDR_ERROR_FLAGS, b);
      chk(24'(b), 24'h01);
      i_host.read_result(v);
      chk(v, 24'h0);
      i_host.read(ADDR_ERROR_FLAGS, b);
      chk(24'(b), 24'h1e);
      // Conversion and low read in one cycle: ready set wins, flags old
      fork
         conv(24'h123456, 3'b000);
         i_host.read(ADDR_RESULT_LOW, b);
      join
      chk(24'(b), 24'h0);
      i_host.read(ADDR_ERROR_FLAGS, b);
      chk(24'(b), 24'h1f);
      final_report();
   end
endmodule

// File: tb/hiresr_host.sv
// Host model that reaches the result slice through its register port
`timescale 1ns/1ps
module hiresr_host
(
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   output logic wr,
   output logic rd,
   output logic [7:0] addr,
   output logic [7:0] wdata
);
   initial
   begin
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
   end

   task automatic write(input logic [7:0] a, input logic [7:0] d);
   begin
      @(posedge clk);
      #1;
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1;
      wr = 1'b0;
      wdata = ~d;
   end
   endtask

   // Missing answer yields unknown data so the compare cannot pass
   task automatic read(input logic [7:0] a, output logic [7:0] d);
   begin
      @(posedge clk);
      #1;
      rd = 1'b1;
      addr = a;
      @(posedge clk);
      #1;
      rd = 1'b0;
      addr = ~a;
      d = rvalid ? rdata : 8'hxx;
   end
   endtask

   task automatic read_result(output logic [23:0] v);
   begin
      read(8'h38, v[7:0]);
      read(8'h39, v[15:8]);
      read(8'h3a, v[23:16]);
   end
   endtask
endmodule
